// ===== hdl/pmc_power_ctrl.sv
// power mode controller with adc offset calibration sequencing
`default_nettype none
module pmc_power_ctrl
   import pmc_pkg::*;
#(
   parameter int unsigned ADC_W = 14,
   parameter int unsigned WAKE_RET_CYC = PMC_WAKE_RET_CYC,
   parameter int unsigned WAKE_SLEEP_CYC = PMC_WAKE_SLEEP_CYC
) (
   input wire logic sys_clk_i,
   input wire logic rst_n_i,
   // register port
   input wire logic [3:0] reg_addr_i,
   input wire logic [31:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   output logic [31:0] reg_rdata_o,
   // mode requests from user logic
   input wire logic sleep_request_i,
   input wire logic retention_select_i,
   // power domains and memories
   output logic pd_aon_on_o,
   output logic pd_ret_on_o,
   output logic pd_sleep_on_o,
   output logic mem_clear_o,
   output logic nvm_load_o,
   input wire logic nvm_load_done_i,
   output logic [1:0] mode_o,
   // adc user side
   input wire logic adc_tick_i,
   input wire logic conv_start_i,
   input wire logic [1:0] conv_chan_i,
   input wire logic cal_start_i,
   output logic [ADC_W-1:0] result_o,
   output logic result_valid_o,
   output logic int_cal_busy_o,
   output logic sys_cal_busy_o,
   // adc converter side
   output logic adc_start_o,
   output logic [1:0] adc_chan_o,
   output logic adc_zero_in_o,
   input wire logic [ADC_W-1:0] adc_data_i,
   input wire logic adc_valid_i
);
   localparam int unsigned SW = ADC_W + 2;
   localparam logic [PMC_TMR_W-1:0] LD_RET = PMC_TMR_W'(WAKE_RET_CYC);
   localparam logic [PMC_TMR_W-1:0] LD_SLP = PMC_TMR_W'(WAKE_SLEEP_CYC);
   localparam logic [PMC_TMR_W-1:0] LD_CAL = PMC_TMR_W'(PMC_INT_CAL_TICKS);

   // code minus midscale, as a signed value
   function automatic logic signed [SW-1:0] ofs_of(input logic [ADC_W-1:0] d);
      logic signed [SW-1:0] mid;
      mid = SW'(1) <<< (ADC_W - 1);
      return $signed(SW'(d)) - mid;
   endfunction

   // clamp a corrected value into the code range
   function automatic logic [ADC_W-1:0] clamp(input logic signed [SW-1:0] v);
      logic signed [SW-1:0] top;
      top = (SW'(1) <<< ADC_W) - SW'(1);
      if (v < 0) return '0;
      else if (v > top) return {ADC_W{1'b1}};
      else return v[ADC_W-1:0];
   endfunction

   logic skip_q;
   logic pair_q;
   pmc_mode_t req_q;
   pmc_state_t state_q;
   pmc_mode_t tgt_q;
   logic cal_pend_q;
   logic wake_go_q;
   logic [PMC_TMR_W-1:0] wake_ld_q;
   logic wake_done;
   logic ical_go_q;
   logic ical_done;
   logic ical_smp_q;
   logic scal_q;
   logic conv_q;
   logic user_q;
   logic cal_in_q;
   logic signed [SW-1:0] int_ofs_q;
   logic signed [SW-1:0] sys_ofs_q;
   logic cal_edge;
   logic conv_ok;

   // mode inputs sampled on the clock
   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         req_q <= PMC_MODE_ON;
      end else if (!sleep_request_i) begin
         req_q <= PMC_MODE_ON;
      end else if (retention_select_i) begin
         req_q <= PMC_MODE_RET;
      end else begin
         req_q <= PMC_MODE_SLEEP;
      end
   end

   // control register
   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         skip_q <= PMC_SKIP_RST;
         pair_q <= PMC_PAIR_RST;
      end else if (reg_wr_i && reg_addr_i == PMC_REG_CTRL) begin
         skip_q <= reg_wdata_i[PMC_CTRL_SKIP_BIT];
         pair_q <= reg_wdata_i[PMC_CTRL_PAIR_BIT];
      end
   end

   // register read data, one cycle after the strobe
   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         reg_rdata_o <= '0;
      end else if (reg_rd_i) begin
         reg_rdata_o <= '0;
         case (reg_addr_i)
            PMC_REG_CTRL: begin
               reg_rdata_o[PMC_CTRL_SKIP_BIT] <= skip_q;
               reg_rdata_o[PMC_CTRL_PAIR_BIT] <= pair_q;
            end
            PMC_REG_STATUS: begin
               reg_rdata_o[PMC_STAT_MODE_LSB +: 2] <= mode_o;
               reg_rdata_o[PMC_STAT_BUSY_BIT] <= (state_q == PMC_ST_WAKE) ||
                  (state_q == PMC_ST_LOAD) || (state_q == PMC_ST_BOOT);
               reg_rdata_o[PMC_STAT_ICAL_BIT] <= int_cal_busy_o;
               reg_rdata_o[PMC_STAT_SCAL_BIT] <= scal_q;
               reg_rdata_o[PMC_STAT_CONV_BIT] <= conv_q;
            end
            PMC_REG_SYS_OFS: begin
               reg_rdata_o <= 32'(sys_ofs_q);
            end
            PMC_REG_INT_OFS: begin
               reg_rdata_o <= 32'(int_ofs_q);
            end
            default: begin
               reg_rdata_o <= '0;
            end
         endcase
      end else begin
         reg_rdata_o <= '0;
      end
   end

   // power mode sequencer
   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state_q <= PMC_ST_BOOT;
         tgt_q <= PMC_MODE_ON;
         cal_pend_q <= 1'b1;
         wake_go_q <= 1'b0;
         wake_ld_q <= '0;
         mem_clear_o <= 1'b0;
         nvm_load_o <= 1'b0;
         ical_go_q <= 1'b0;
      end else begin
         wake_go_q <= 1'b0;
         mem_clear_o <= 1'b0;
         ical_go_q <= 1'b0;
         case (state_q)
            PMC_ST_BOOT: begin
               state_q <= PMC_ST_LOAD;
               nvm_load_o <= !skip_q;
            end
            PMC_ST_LOAD: begin
               if (skip_q || nvm_load_done_i) begin
                  nvm_load_o <= 1'b0;
                  ical_go_q <= cal_pend_q;
                  cal_pend_q <= 1'b0;
                  state_q <= (tgt_q == PMC_MODE_RET) ? PMC_ST_RET : PMC_ST_ON;
               end
            end
            PMC_ST_ON: begin
               if (req_q == PMC_MODE_RET) begin
                  state_q <= PMC_ST_RET;
               end else if (req_q == PMC_MODE_SLEEP) begin
                  mem_clear_o <= 1'b1;
                  state_q <= PMC_ST_SLEEP;
               end
            end
            PMC_ST_RET: begin
               if (req_q == PMC_MODE_ON) begin
                  wake_go_q <= 1'b1;
                  wake_ld_q <= LD_RET;
                  tgt_q <= PMC_MODE_ON;
                  state_q <= PMC_ST_WAKE;
               end else if (req_q == PMC_MODE_SLEEP) begin
                  mem_clear_o <= 1'b1;
                  state_q <= PMC_ST_SLEEP;
               end
            end
            PMC_ST_SLEEP: begin
               if (req_q != PMC_MODE_SLEEP) begin
                  wake_go_q <= 1'b1;
                  wake_ld_q <= LD_SLP;
                  tgt_q <= req_q;
                  cal_pend_q <= 1'b1;
                  state_q <= PMC_ST_WAKE;
               end
            end
            PMC_ST_WAKE: begin
               if (wake_done) begin
                  nvm_load_o <= !skip_q;
                  state_q <= PMC_ST_LOAD;
               end
            end
            default: begin
               state_q <= PMC_ST_BOOT;
            end
         endcase
      end
   end

   pmc_timer #(
      .W(PMC_TMR_W)
   ) u_wake_tmr (
      .sys_clk_i(sys_clk_i),
      .rst_n_i(rst_n_i),
      .start_i(wake_go_q),
      .load_i(wake_ld_q),
      .tick_i(1'b1),
      .busy_o(),
      .done_o(wake_done)
   );

   // domain switches and reported mode
   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         pd_aon_on_o <= 1'b0;
         pd_ret_on_o <= 1'b0;
         pd_sleep_on_o <= 1'b0;
         mode_o <= PMC_MODE_ON;
      end else begin
         pd_aon_on_o <= 1'b1;
         pd_ret_on_o <= state_q != PMC_ST_SLEEP;
         pd_sleep_on_o <= (state_q != PMC_ST_SLEEP) && (state_q != PMC_ST_RET);
         case (state_q)
            PMC_ST_RET: mode_o <= PMC_MODE_RET;
            PMC_ST_SLEEP: mode_o <= PMC_MODE_SLEEP;
            default: mode_o <= PMC_MODE_ON;
         endcase
      end
   end

   pmc_timer #(
      .W(PMC_TMR_W)
   ) u_ical_tmr (
      .sys_clk_i(sys_clk_i),
      .rst_n_i(rst_n_i),
      .start_i(ical_go_q),
      .load_i(LD_CAL),
      .tick_i(adc_tick_i),
      .busy_o(),
      .done_o(ical_done)
   );

   // calibration start edge detect
   assign cal_edge = cal_start_i && !cal_in_q;
   assign conv_ok = (state_q == PMC_ST_ON) && !int_cal_busy_o && !scal_q && !conv_q;

   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         cal_in_q <= 1'b0;
      end else begin
         cal_in_q <= cal_start_i;
      end
   end

   // internal calibration window
   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         int_cal_busy_o <= 1'b0;
      end else if (ical_go_q) begin
         int_cal_busy_o <= 1'b1;
      end else if (ical_done) begin
         int_cal_busy_o <= 1'b0;
      end
   end

   // converter launch and calibration capture
   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         adc_start_o <= 1'b0;
         adc_chan_o <= '0;
         adc_zero_in_o <= 1'b0;
         conv_q <= 1'b0;
         user_q <= 1'b0;
         scal_q <= 1'b0;
         ical_smp_q <= 1'b0;
         int_ofs_q <= '0;
         sys_ofs_q <= '0;
      end else begin
         adc_start_o <= 1'b0;
         if (ical_go_q && !conv_q) begin
            adc_start_o <= 1'b1;
            adc_zero_in_o <= 1'b1;
            ical_smp_q <= 1'b1;
            conv_q <= 1'b1;
         end else if (cal_edge && !conv_q && !scal_q && !int_cal_busy_o &&
                      state_q == PMC_ST_ON) begin
            scal_q <= 1'b1;
            adc_start_o <= 1'b1;
            adc_chan_o <= pair_q ? PMC_PAIR1_CHAN : PMC_PAIR0_CHAN;
            conv_q <= 1'b1;
         end else if (conv_start_i && conv_ok) begin
            adc_start_o <= 1'b1;
            adc_chan_o <= conv_chan_i;
            user_q <= 1'b1;
            conv_q <= 1'b1;
         end
         if (adc_valid_i && conv_q) begin
            conv_q <= 1'b0;
            user_q <= 1'b0;
            adc_zero_in_o <= 1'b0;
            if (ical_smp_q) begin
               int_ofs_q <= ofs_of(adc_data_i);
               ical_smp_q <= 1'b0;
            end else if (scal_q) begin
               sys_ofs_q <= ofs_of(adc_data_i);
               scal_q <= 1'b0;
            end
         end
      end
   end

   assign sys_cal_busy_o = scal_q;

   // corrected conversion results
   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         result_o <= '0;
         result_valid_o <= 1'b0;
      end else begin
         result_valid_o <= adc_valid_i && user_q;
         if (adc_valid_i && user_q) begin
            if (adc_chan_o[1] == pair_q) begin
               result_o <= clamp($signed(SW'(adc_data_i)) - int_ofs_q - sys_ofs_q);
            end else begin
               result_o <= clamp($signed(SW'(adc_data_i)) - int_ofs_q);
            end
         end
      end
   end
endmodule
`default_nettype wire

// ===== hdl/pmc_pkg.sv
// constants and types shared by the power mode controller
`default_nettype none
package pmc_pkg;
   // power modes
   typedef enum logic [1:0] {PMC_MODE_ON, PMC_MODE_RET, PMC_MODE_SLEEP} pmc_mode_t;
   // controller states
   typedef enum logic [2:0] {
      PMC_ST_BOOT, PMC_ST_LOAD, PMC_ST_ON, PMC_ST_RET, PMC_ST_SLEEP, PMC_ST_WAKE
   } pmc_state_t;

   // clock and timing
   localparam int unsigned PMC_CLK_PERIOD_NS = 100;
   localparam int unsigned PMC_WAKE_RET_NS = 410_000;
   localparam int unsigned PMC_WAKE_SLEEP_NS = 1_370_000;
   localparam int unsigned PMC_WAKE_RET_CYC = PMC_WAKE_RET_NS / PMC_CLK_PERIOD_NS;
   localparam int unsigned PMC_WAKE_SLEEP_CYC = PMC_WAKE_SLEEP_NS / PMC_CLK_PERIOD_NS;
   localparam int unsigned PMC_INT_CAL_TICKS = 6415;
   localparam int unsigned PMC_TMR_W = 14;

   // register map
   localparam logic [3:0] PMC_REG_CTRL = 4'h0;
   localparam logic [3:0] PMC_REG_STATUS = 4'h4;
   localparam logic [3:0] PMC_REG_SYS_OFS = 4'h8;
   localparam logic [3:0] PMC_REG_INT_OFS = 4'hC;
   // control fields
   localparam int unsigned PMC_CTRL_SKIP_BIT = 0;
   localparam int unsigned PMC_CTRL_PAIR_BIT = 1;
   localparam logic PMC_SKIP_RST = 1'h0;
   localparam logic PMC_PAIR_RST = 1'h0;
   // status fields
   localparam int unsigned PMC_STAT_MODE_LSB = 0;
   localparam int unsigned PMC_STAT_BUSY_BIT = 2;
   localparam int unsigned PMC_STAT_ICAL_BIT = 3;
   localparam int unsigned PMC_STAT_SCAL_BIT = 4;
   localparam int unsigned PMC_STAT_CONV_BIT = 5;
   // channel of each calibrated pair
   localparam logic [1:0] PMC_PAIR0_CHAN = 2'h0;
   localparam logic [1:0] PMC_PAIR1_CHAN = 2'h2;
endpackage
`default_nettype wire

// ===== hdl/pmc_timer.sv
// down counter that times a span of ticks
`default_nettype none
module pmc_timer
   import pmc_pkg::*;
#(
   parameter int unsigned W = PMC_TMR_W
) (
   input wire logic sys_clk_i,
   input wire logic rst_n_i,
   input wire logic start_i,
   input wire logic [W-1:0] load_i,
   input wire logic tick_i,
   output logic busy_o,
   output logic done_o
);
   logic [W-1:0] cnt_q;

   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         cnt_q <= '0;
         busy_o <= 1'b0;
         done_o <= 1'b0;
      end else begin
         done_o <= 1'b0;
         if (start_i) begin
            cnt_q <= load_i;
            busy_o <= 1'b1;
         end else if (busy_o && tick_i) begin
            cnt_q <= cnt_q - 1'b1;
            if (cnt_q <= {{(W-1){1'b0}}, 1'b1}) begin
               busy_o <= 1'b0;
               done_o <= 1'b1;
            end
         end
      end
   end
endmodule
`default_nettype wire

// ===== testbench/pmc_power_ctrl_asserts.sv
// assertion checker for the power mode controller
`default_nettype none
module pmc_power_ctrl_asserts
   import pmc_pkg::*;
(
   input wire logic sys_clk_i,
   input wire logic rst_n_i,
   input wire logic pd_aon_on_o,
   input wire logic pd_ret_on_o,
   input wire logic pd_sleep_on_o,
   input wire logic mem_clear_o,
   input wire logic [1:0] mode_o,
   input wire logic conv_start_i,
   input wire logic cal_start_i,
   input wire logic adc_start_o,
   input wire logic adc_zero_in_o,
   input wire logic adc_valid_i,
   input wire logic result_valid_o,
   input wire logic int_cal_busy_o,
   input wire logic sys_cal_busy_o
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (!rst_n_i);
   sequence s_cal_launch;
      adc_start_o && sys_cal_busy_o;
   endsequence
   sequence s_edge_in_cal;
      $rose(cal_start_i) && int_cal_busy_o;
   endsequence
   a_sleep_domains: assert property (mode_o == 2'h2 [*4] |->
      pd_aon_on_o && !pd_ret_on_o && !pd_sleep_on_o) else $error("sleep domain state wrong");
   a_ret_domains: assert property (mode_o == 2'h1 [*4] |->
      pd_aon_on_o && pd_ret_on_o && !pd_sleep_on_o) else $error("retention domain state wrong");
   a_domain_nesting: assert property (pd_sleep_on_o |-> pd_ret_on_o && pd_aon_on_o)
      else $error("sleep domain on without others");
   a_clear_pulse: assert property (mem_clear_o |=> !mem_clear_o)
      else $error("clear pulse too long");
   a_clear_to_sleep: assert property (mem_clear_o |-> ##[0:4] mode_o == 2'h2)
      else $error("clear without sleep entry");
   a_cal_launch: assert property ($rose(sys_cal_busy_o) |-> s_cal_launch)
      else $error("system calibration without converter start");
   a_conv_ignored: assert property (sys_cal_busy_o && !adc_start_o && conv_start_i
      |=> !adc_start_o) else $error("conversion started during calibration");
   a_edge_blocked: assert property (s_edge_in_cal |=> !sys_cal_busy_o)
      else $error("calibration edge taken while busy");
   a_zero_in_cal: assert property (adc_zero_in_o |-> int_cal_busy_o)
      else $error("zero input outside internal calibration");
   a_result_cause: assert property (result_valid_o |-> $past(adc_valid_i))
      else $error("result without converter data");
endmodule
bind pmc_power_ctrl pmc_power_ctrl_asserts u_chk (
   .sys_clk_i(sys_clk_i),
   .rst_n_i(rst_n_i),
   .pd_aon_on_o(pd_aon_on_o),
   .pd_ret_on_o(pd_ret_on_o),
   .pd_sleep_on_o(pd_sleep_on_o),
   .mem_clear_o(mem_clear_o),
   .mode_o(mode_o),
   .conv_start_i(conv_start_i),
   .cal_start_i(cal_start_i),
   .adc_start_o(adc_start_o),
   .adc_zero_in_o(adc_zero_in_o),
   .adc_valid_i(adc_valid_i),
   .result_valid_o(result_valid_o),
   .int_cal_busy_o(int_cal_busy_o),
   .sys_cal_busy_o(sys_cal_busy_o)
);
`default_nettype wire

// ===== testbench/pmc_adc_model.sv
// converter and nonvolatile memory model facing the controller
`default_nettype none
module pmc_adc_model (
   input wire logic sys_clk_i,
   input wire logic rst_n_i,
   input wire logic adc_start_i,
   input wire logic nvm_load_i,
   input wire logic [13:0] sample_i,
   input wire logic [3:0] lat_i,
   output logic [13:0] adc_data_o,
   output logic adc_valid_o,
   output logic nvm_done_o
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [3:0] cnt_q;
   logic [3:0] nvm_q;
   // converter answers after lat_i cycles, data churns otherwise
   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         cnt_q <= 4'h0;
         adc_valid_o <= 1'b0;
         adc_data_o <= 14'h0;
      end else begin
         adc_valid_o <= (cnt_q == 4'h1);
         adc_data_o <= (cnt_q == 4'h1) ? sample_i : ~adc_data_o;
         if (adc_start_i)
            cnt_q <= lat_i;
         else if (cnt_q != 4'h0)
            cnt_q <= cnt_q - 4'h1;
      end
   end
   // table copy finishes after lat_i + 1 cycles of request
   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         nvm_q <= 4'h0;
         nvm_done_o <= 1'b0;
      end else begin
         nvm_q <= nvm_load_i ? nvm_q + 4'h1 : 4'h0;
         nvm_done_o <= nvm_load_i && nvm_q == lat_i;
      end
   end
endmodule
`default_nettype wire

// ===== testbench/testbench.sv
// self-checking bench for the power mode controller
`default_nettype none
module testbench
   import pmc_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int WR = 20;
   localparam int WS = 40;
   logic sys_clk_i = 1'b0, rst_n_i = 1'b0, reg_wr_i = 1'b0, reg_rd_i = 1'b0, rd_d = 1'b0;
   logic sleep_request_i = 1'b0, retention_select_i = 1'b0, adc_tick_i = 1'b0;
   logic conv_start_i = 1'b0, cal_start_i = 1'b0;
   logic [3:0] reg_addr_i = 4'h0;
   logic [3:0] lat = 4'h3;
   logic [31:0] reg_wdata_i = 32'h0;
   logic [1:0] conv_chan_i = 2'h0;
   logic [13:0] sample = 14'h2005;
   logic [31:0] reg_rdata_o;
   logic pd_aon_on_o, pd_ret_on_o, pd_sleep_on_o, mem_clear_o, nvm_load_o, nvm_load_done_i;
   logic result_valid_o, int_cal_busy_o, sys_cal_busy_o, adc_start_o, adc_zero_in_o, adc_valid_i;
   logic [1:0] mode_o, adc_chan_o;
   logic [13:0] result_o, adc_data_i;
   logic [31:0] exp_q[$];
   int fail_count = 0, n_tests = 0, tick_n = 0, clr_n = 0, nvm_n = 0;
   pmc_power_ctrl #(.WAKE_RET_CYC(WR), .WAKE_SLEEP_CYC(WS)) DUT (.*);
   pmc_adc_model u_far (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .adc_start_i(adc_start_o),
      .nvm_load_i(nvm_load_o), .sample_i(sample), .lat_i(lat), .adc_data_o(adc_data_i),
      .adc_valid_o(adc_valid_i), .nvm_done_o(nvm_load_done_i));
   always #50 sys_clk_i = ~sys_clk_i;
   task give_verdict();
      if (fail_count == 0 && n_tests > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   task check(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         fail_count++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   // watcher: compares each result and read answer with the oldest note
   always @(posedge sys_clk_i) begin
      adc_tick_i <= ~adc_tick_i;
      rd_d <= reg_rd_i;
      if (int_cal_busy_o === 1'b1 && adc_tick_i === 1'b1)
         tick_n <= tick_n + 1;
      if (mem_clear_o === 1'b1)
         clr_n <= clr_n + 1;
      if (nvm_load_o === 1'b1)
         nvm_n <= nvm_n + 1;
      if ((result_valid_o === 1'b1 || rd_d === 1'b1) && exp_q.size() > 0)
         check(result_valid_o === 1'b1 ? {18'h0, result_o} : reg_rdata_o, exp_q.pop_front());
   end
   function automatic logic probe(input int s);
      case (s)
         0: return nvm_load_o;
         1: return int_cal_busy_o;
         2: return sys_cal_busy_o;
         3: return result_valid_o;
         default: return mode_o === 2'(s - 4);
      endcase
   endfunction
   task automatic wait_for(input int s, input logic v, input int max, output int n);
      n = 0;
      #1;
      while (probe(s) !== v && n < max) begin
         @(posedge sys_clk_i);
         #1;
         n++;
      end
      if (n >= max) begin
         fail_count++;
         $display("[FAIL] %0t wait ran out", $time);
         give_verdict();
      end else begin
         @(posedge sys_clk_i);
      end
   endtask
   task reg_wr(input logic [3:0] a, input logic [31:0] d);
      reg_addr_i <= a;
      reg_wdata_i <= d;
      reg_wr_i <= 1'b1;
      @(posedge sys_clk_i);
      reg_wr_i <= 1'b0;
   endtask
   task reg_rd(input logic [3:0] a, input logic [31:0] e);
      exp_q.push_back(e);
      reg_addr_i <= a;
      reg_rd_i <= 1'b1;
      @(posedge sys_clk_i);
      reg_rd_i <= 1'b0;
      repeat (2) @(posedge sys_clk_i);
   endtask
   task automatic mode_to(input logic s, input logic r, input int m);
      int n;
      repeat (50) @(posedge sys_clk_i);
      sleep_request_i <= s;
      retention_select_i <= r;
      wait_for(m + 4, 1'b1, 200, n);
      repeat (6) @(posedge sys_clk_i);
   endtask
   initial begin
      int n;
      int d;
      void'($urandom(32'hFFFAC435));
      repeat (16) @(posedge sys_clk_i);
      rst_n_i <= 1'b1;
      wait_for(1, 1'b1, 200, n);
      cal_start_i <= 1'b1;
      wait_for(1, 1'b0, 14000, n);
      check({31'h0, tick_n >= 6415 && tick_n <= 6416}, 32'h1);
      repeat (4) @(posedge sys_clk_i);
      check({31'h0, sys_cal_busy_o}, 32'h0);
      cal_start_i <= 1'b0;
      reg_rd(PMC_REG_INT_OFS, 32'h5);
      reg_rd(4'h2, 32'h0);
      reg_rd(PMC_REG_CTRL, 32'h0);
      reg_wr(PMC_REG_CTRL, 32'h2);
      reg_rd(PMC_REG_CTRL, 32'h2);
      sample <= 14'h1FF4;
      lat <= 4'h6;
      cal_start_i <= 1'b1;
      wait_for(2, 1'b1, 10, n);
      conv_start_i <= 1'b1;
      @(posedge sys_clk_i);
      conv_start_i <= 1'b0;
      wait_for(2, 1'b0, 20, n);
      cal_start_i <= 1'b0;
      reg_rd(PMC_REG_SYS_OFS, 32'hFFFFFFF4);
      for (int c = 0; c < 4; c++) begin
         d = 200 + ($urandom % 15000);
         sample <= 14'(d);
         conv_chan_i <= 2'(c);
         conv_start_i <= 1'b1;
         exp_q.push_back(32'(d - 5 + (c > 1 ? 12 : 0)));
         @(posedge sys_clk_i);
         conv_start_i <= 1'b0;
         @(posedge sys_clk_i);
         cal_start_i <= 1'b1;
         wait_for(3, 1'b1, 20, n);
         check({31'h0, sys_cal_busy_o}, 32'h0);
         cal_start_i <= 1'b0;
         @(posedge sys_clk_i);
      end
      mode_to(1'b1, 1'b1, 1);
      check({29'h0, pd_aon_on_o, pd_ret_on_o, pd_sleep_on_o}, 32'h6);
      check(32'(clr_n), 32'h0);
      reg_rd(PMC_REG_STATUS, 32'h1);
      sleep_request_i <= 1'b0;
      wait_for(0, 1'b1, 100, n);
      check({31'h0, n >= WR && n <= WR + 8}, 32'h1);
      wait_for(0, 1'b0, 100, n);
      repeat (6) @(posedge sys_clk_i);
      check({31'h0, int_cal_busy_o}, 32'h0);
      reg_rd(PMC_REG_SYS_OFS, 32'hFFFFFFF4);
      mode_to(1'b1, 1'b0, 2);
      check({29'h0, pd_aon_on_o, pd_ret_on_o, pd_sleep_on_o}, 32'h4);
      check(32'(clr_n), 32'h1);
      retention_select_i <= 1'b1;
      wait_for(0, 1'b1, 100, n);
      check({31'h0, n >= WS && n <= WS + 8}, 32'h1);
      check({30'h0, mode_o}, 32'h0);
      wait_for(5, 1'b1, 100, n);
      sleep_request_i <= 1'b0;
      wait_for(0, 1'b1, 100, n);
      wait_for(4, 1'b1, 100, n);
      wait_for(1, 1'b0, 14000, n);
      repeat (4) @(posedge sys_clk_i);
      reg_wr(PMC_REG_CTRL, 32'h3);
      mode_to(1'b1, 1'b0, 2);
      d = nvm_n;
      sleep_request_i <= 1'b0;
      wait_for(1, 1'b1, WS + 40, n);
      check(32'(nvm_n), 32'(d));
      give_verdict();
   end
endmodule
`default_nettype wire
